// *** bridge_hdr_pkg.sv ***
/*
  Package for the bridge configuration header bank: byte offsets, field positions,
  reset values and the carrier structs shared by the register bank.
  Assumes a byte-wide configuration port with one-cycle read latency.
*/
package bridge_hdr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte offsets
  localparam logic [7:0] OFS_PRIMARY_LATENCY_TIMER   = 8'h0d;
  localparam logic [7:0] OFS_HEADER_LAYOUT_CODE      = 8'h0e;
  localparam logic [7:0] OFS_SELF_TEST_CONTROL       = 8'h0f;
  localparam logic [7:0] OFS_BASE_ADDRESS_ZERO       = 8'h10;
  localparam logic [7:0] OFS_BASE_ADDRESS_ONE        = 8'h14;
  localparam logic [7:0] OFS_UPSTREAM_BUS_NUMBER     = 8'h18;
  localparam logic [7:0] OFS_DOWNSTREAM_BUS_NUMBER   = 8'h19;
  localparam logic [7:0] OFS_HIGHEST_BUS_NUMBER      = 8'h1a;
  localparam logic [7:0] OFS_SECONDARY_LATENCY_TIMER = 8'h1b;
  localparam logic [7:0] OFS_IO_WINDOW_BASE          = 8'h1c;
  localparam logic [7:0] OFS_IO_WINDOW_LIMIT         = 8'h1d;
  localparam logic [7:0] OFS_BAR_SPAN                = 8'h08;

  ////////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int         IO_CAP_BIT         = 0;
  localparam int         IO_ADDR_LSB        = 4;
  localparam logic [7:0] RST_LATENCY_TIMER  = 8'h00;
  localparam logic [7:0] RST_HEADER_LAYOUT  = 8'h01;
  localparam logic [7:0] RST_SELF_TEST      = 8'h00;
  localparam logic [7:0] RST_BAR_BYTE       = 8'h00;
  localparam logic [7:0] RST_BUS_NUMBER     = 8'h00;
  localparam logic       RST_IO_CAP         = 1'b1;
  localparam logic [3:0] RST_IO_BASE        = 4'hf;
  localparam logic [3:0] RST_IO_LIMIT       = 4'h0;
  localparam logic [11:0] IO_LIMIT_LOW_ONES = 12'hfff;

  typedef struct packed {
    logic [7:0] upstream;
    logic [7:0] downstream;
    logic [7:0] highest;
  } bus_numbers_s;

  typedef struct packed {
    logic       cap32;
    logic [3:0] base;
    logic [3:0] limit;
  } io_window_s;

endpackage

// *** bridge_config_header_io_window.sv ***
/*
  Configuration header bank of a bridge function, offsets 0x0d to 0x1d, plus the
  I/O window decoder that the base and limit pair steers.
  Assumes a byte-wide config port: one-cycle strobes, read data in the next cycle.
*/
// Decided for this implementation: the address-and-strobe port.
// Contract
// - Primary latency timer byte is read-only and reads zero.
// - Header type byte reads one, a type 1 single-function layout.
// - Self-test byte reads zero; no built-in self-test.
// - Both 32-bit base address registers read zero and claim nothing.
// - Upstream bus number is read/write, resets zero, no behavioural effect.
// - Downstream bus number is read/write, resets zero.
// - Highest bus number is read/write, resets zero.
// - Secondary latency timer byte is read-only and reads zero.
// - Base bit 0 is capability flag, resets one; one means 32-bit I/O.
// - Limit bit 0 mirrors the capability flag, read-only.
// - Base bits 7:4 read/write, reset 0xf, give address bits 15:12 of bottom.
// - Limit bits 7:4 read/write, reset zero, top low twelve bits all ones.
// - Base and limit together decide which I/O transactions are forwarded.
`timescale 1ns/10ps
module bridge_config_header_io_window
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [ADDR_W-1:0]            cfg_addr,
  input  wire logic [7:0]                   cfg_wdata,
  input  wire logic                         cfg_write,
  input  wire logic                         cfg_read,
  output logic      [7:0]                   cfg_rdata,
  input  wire logic [31:0]                  io_req_addr,
  output logic                              io_forward,
  output bridge_hdr_pkg::bus_numbers_s      bus_numbers,
  output bridge_hdr_pkg::io_window_s        io_window
);

  if (ADDR_W < 8)
  begin : g_chk
    $error("ADDR_W must cover offset 0x1d");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable state
  bridge_hdr_pkg::bus_numbers_s bus_q;
  bridge_hdr_pkg::bus_numbers_s bus_d;
  bridge_hdr_pkg::io_window_s   win_q;
  bridge_hdr_pkg::io_window_s   win_d;
  logic [7:0]                   rdata_q;
  logic [7:0]                   rdata_d;
  logic [7:0]                   ofs;

  assign ofs = cfg_addr[7:0];

  always_comb
  begin
    bus_d = bus_q;
    win_d = win_q;
    if (cfg_write)
    begin
      if (ofs == bridge_hdr_pkg::OFS_UPSTREAM_BUS_NUMBER)
      begin
        bus_d.upstream = cfg_wdata;
      end
      else if (ofs == bridge_hdr_pkg::OFS_DOWNSTREAM_BUS_NUMBER)
      begin
        bus_d.downstream = cfg_wdata;
      end
      else if (ofs == bridge_hdr_pkg::OFS_HIGHEST_BUS_NUMBER)
      begin
        bus_d.highest = cfg_wdata;
      end
      else if (ofs == bridge_hdr_pkg::OFS_IO_WINDOW_BASE)
      begin
        // Reserved bits 3:1 are dropped here
        win_d.cap32 = cfg_wdata[bridge_hdr_pkg::IO_CAP_BIT];
        win_d.base  = cfg_wdata[7:4];
      end
      else if (ofs == bridge_hdr_pkg::OFS_IO_WINDOW_LIMIT)
      begin
        // Bit 0 is a mirror, so a write there cannot move the flag
        win_d.limit = cfg_wdata[7:4];
      end
      // Every other offset is read-only; writes fall through unchanged
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (cfg_read)
    begin
      if (ofs == bridge_hdr_pkg::OFS_PRIMARY_LATENCY_TIMER)
      begin
        rdata_d = bridge_hdr_pkg::RST_LATENCY_TIMER;
      end
      else if (ofs == bridge_hdr_pkg::OFS_HEADER_LAYOUT_CODE)
      begin
        rdata_d = bridge_hdr_pkg::RST_HEADER_LAYOUT;
      end
      else if (ofs == bridge_hdr_pkg::OFS_SELF_TEST_CONTROL)
      begin
        rdata_d = bridge_hdr_pkg::RST_SELF_TEST;
      end
      else if (ofs >= bridge_hdr_pkg::OFS_BASE_ADDRESS_ZERO &&
               ofs <  8'(bridge_hdr_pkg::OFS_BASE_ADDRESS_ZERO + bridge_hdr_pkg::OFS_BAR_SPAN))
      begin
        rdata_d = bridge_hdr_pkg::RST_BAR_BYTE;
      end
      else if (ofs == bridge_hdr_pkg::OFS_UPSTREAM_BUS_NUMBER)
      begin
        rdata_d = bus_q.upstream;
      end
      else if (ofs == bridge_hdr_pkg::OFS_DOWNSTREAM_BUS_NUMBER)
      begin
        rdata_d = bus_q.downstream;
      end
      else if (ofs == bridge_hdr_pkg::OFS_HIGHEST_BUS_NUMBER)
      begin
        rdata_d = bus_q.highest;
      end
      else if (ofs == bridge_hdr_pkg::OFS_SECONDARY_LATENCY_TIMER)
      begin
        rdata_d = bridge_hdr_pkg::RST_LATENCY_TIMER;
      end
      else if (ofs == bridge_hdr_pkg::OFS_IO_WINDOW_BASE)
      begin
        rdata_d = {win_q.base, 3'h0, win_q.cap32};
      end
      else if (ofs == bridge_hdr_pkg::OFS_IO_WINDOW_LIMIT)
      begin
        rdata_d = {win_q.limit, 3'h0, win_q.cap32};
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_q       <= '{bridge_hdr_pkg::RST_BUS_NUMBER, bridge_hdr_pkg::RST_BUS_NUMBER,
                       bridge_hdr_pkg::RST_BUS_NUMBER};
      win_q       <= '{bridge_hdr_pkg::RST_IO_CAP, bridge_hdr_pkg::RST_IO_BASE,
                       bridge_hdr_pkg::RST_IO_LIMIT};
      rdata_q     <= 8'h00;
    end
    else
    begin
      bus_q   <= bus_d;
      win_q   <= win_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // I/O window decode, combinational on the request address.
  // In 16-bit mode the upper address half must be zero; upper base and limit
  // registers live outside this bank and are taken as zero.
  logic [31:0] win_lo;
  logic [31:0] win_hi;

  always_comb
  begin
    win_lo     = {16'h0000, win_q.base, 12'h000};
    win_hi     = {16'h0000, win_q.limit, bridge_hdr_pkg::IO_LIMIT_LOW_ONES};
    // Base above limit gives an empty window by the comparison itself
    io_forward = (io_req_addr >= win_lo) && (io_req_addr <= win_hi);
  end

  assign cfg_rdata   = rdata_q;
  assign bus_numbers = bus_q;
  assign io_window   = win_q;

endmodule

// *** bridge_hdr_props.sv ***
/* Checker for the bridge header bank, watching only its ports.
   Assumes one clock and the active-high asynchronous reset. */
`timescale 1ns/10ps
module bridge_hdr_props
#(
  parameter int ADDR_W = 8
)
(
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic [ADDR_W-1:0]            cfg_addr,
  input wire logic [7:0]                   cfg_wdata,
  input wire logic                         cfg_write,
  input wire logic                         cfg_read,
  input wire logic [7:0]                   cfg_rdata,
  input wire logic [31:0]                  io_req_addr,
  input wire logic                         io_forward,
  input wire bridge_hdr_pkg::bus_numbers_s bus_numbers,
  input wire bridge_hdr_pkg::io_window_s   io_window
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  a_rdata_idle: assert property (!cfg_read |=> cfg_rdata == 8'h00) else $error("rdata not idle");
  a_header_code: assert property (cfg_read && cfg_addr == 8'h0e |=> cfg_rdata == 8'h01) else $error("bad hdr");
  a_ro_zero: assert property (cfg_read && cfg_addr inside {8'h0d, 8'h0f, [8'h10:8'h17], 8'h1b}
    |=> cfg_rdata == 8'h00) else $error("ro byte not zero");
  a_up_write: assert property (cfg_write && cfg_addr == 8'h18
    |=> bus_numbers.upstream == $past(cfg_wdata)) else $error("upstream lost");
  a_down_write: assert property (cfg_write && cfg_addr == 8'h19
    |=> bus_numbers.downstream == $past(cfg_wdata)) else $error("downstream lost");
  a_top_write: assert property (cfg_write && cfg_addr == 8'h1a
    |=> bus_numbers.highest == $past(cfg_wdata)) else $error("highest lost");
  a_base_write: assert property (cfg_write && cfg_addr == 8'h1c |=> io_window.base == $past(cfg_wdata[7:4])
    && io_window.cap32 == $past(cfg_wdata[0])) else $error("base lost");
  a_limit_write: assert property (cfg_write && cfg_addr == 8'h1d |=> io_window.limit == $past(cfg_wdata[7:4])
    && $stable(io_window.cap32)) else $error("limit lost");
  a_limit_mirror: assert property (cfg_read && cfg_addr == 8'h1d
    |=> cfg_rdata == {io_window.limit, 3'h0, io_window.cap32}) else $error("mirror");
  a_fwd_decode: assert property (io_forward == (io_req_addr[31:16] == 16'h0000
    && io_req_addr[15:12] >= io_window.base && io_req_addr[15:12] <= io_window.limit))
    else $error("decode");
  c_base_wr: cover property (cfg_write && cfg_addr == 8'h1c);
  c_fwd: cover property (io_forward);
  c_b2b: cover property (cfg_write ##1 cfg_read);
endmodule
bind bridge_config_header_io_window bridge_hdr_props #(.ADDR_W(ADDR_W)) u_bridge_hdr_props (.clk(clk), .rst(rst),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
  .io_req_addr(io_req_addr), .io_forward(io_forward), .bus_numbers(bus_numbers), .io_window(io_window));

// *** test_bridge_config_header_io_window.sv ***
/* Bench for the bridge header bank: register sweep and window decode.
   Assumes design and checker are compiled first. */
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %0t %h %h", $time, a, e); end end
module test_bridge_config_header_io_window;
  logic        clk = 1'b0, rst = 1'b1, cfg_write = 1'b0, cfg_read = 1'b0, rd_seen = 1'b0, io_forward;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, d, m [0:31], exp_q [$];
  logic [31:0] io_req_addr = 32'h0;
  logic [7:0]  exp_v;
  bridge_hdr_pkg::bus_numbers_s bus_numbers;
  bridge_hdr_pkg::io_window_s   io_window;
  int          miscompares = 0, tests_run = 0;
  always #12.5 clk = ~clk;
  bridge_config_header_io_window u_bridge_config_header_io_window (.clk(clk), .rst(rst), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_rdata(cfg_rdata),
    .io_req_addr(io_req_addr), .io_forward(io_forward), .bus_numbers(bus_numbers), .io_window(io_window));
  ////////////////////////////////////////
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    cfg_write <= w;
    cfg_read  <= r;
    cfg_addr  <= a;
    cfg_wdata <= v;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, a, 8'($urandom));
  endtask
  // Decode is combinational, so it is judged mid-cycle once inputs settle
  task automatic fwd(input logic [31:0] x, input logic e);
    cfg_write   <= 1'b0;
    cfg_read    <= 1'b0;
    io_req_addr <= x;
    @(negedge clk);
    `CHK(io_forward, e)
    @(posedge clk);
  endtask
  task automatic results;
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) rd_seen <= cfg_read;
  // Pop once per result; the macro reads its expected value twice on a mismatch
  always @(negedge clk)
    if (rd_seen)
    begin
      exp_v = exp_q.pop_front();
      `CHK(cfg_rdata, exp_v)
    end
  initial
  begin
    #20us;
    miscompares++;
    results;
  end
  initial
  begin
    void'($urandom(84));
    foreach (m[i]) m[i] = 8'h00;
    m[14] = 8'h01;
    m[28] = 8'hf1;
    m[29] = 8'h01;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    fwd(32'h0000_f000, 1'b0);
    for (int a = 12; a < 32; a++)
      rd(a[7:0], m[a]);
    for (int a = 12; a < 32; a++)
    begin
      d = 8'($urandom);
      acc(1'b1, 1'b0, a[7:0], d);
      if (a inside {24, 25, 26}) m[a] = d;
      if (a == 28) m[a] = {d[7:4], 3'h0, d[0]};
      if (a == 29) m[a] = {d[7:4], 3'h0, m[28][0]};
    end
    // Written several edges ago, so these outputs are settled here
    `CHK(bus_numbers, {m[24], m[25], m[26]})
    `CHK(io_window, {m[28][0], m[28][7:4], m[29][7:4]})
    for (int a = 12; a < 32; a++)
      rd(a[7:0], m[a]);
    acc(1'b1, 1'b0, 8'h1c, 8'h50);
    rd(8'h1c, 8'h50);
    rd(8'h1d, {m[29][7:4], 4'h0});
    acc(1'b1, 1'b0, 8'h1c, 8'h11);
    acc(1'b1, 1'b0, 8'h1d, 8'h2e);
    rd(8'h1d, 8'h21);
    fwd(32'h0000_1000, 1'b1);
    fwd(32'h0000_2fff, 1'b1);
    fwd(32'h0000_0fff, 1'b0);
    fwd(32'h0000_3000, 1'b0);
    fwd(32'h0001_1000, 1'b0);
    acc(1'b1, 1'b0, 8'h1c, 8'h31);
    fwd(32'h0000_3000, 1'b0);
    fwd(32'h0000_2000, 1'b0);
    repeat (2) @(posedge clk);
    results;
  end
endmodule
